// ==== hdl/sosm_top.v ====
// Overview of operation
// R1 - Monitor copies go to incrementing addresses
// R2 - Monitor uses D16; only A24 or shared RAM
// R3 - Region is blocks times size plus four
// R4 - First four bytes are the flag
// R5 - Flag zero: copy block, then set one
// R6 - Host reads block then clears flag
// R7 - Flag nonzero: skip copy, still pass data
// R8 - Host presets flags and block set first
// R9 - Wait-bit codes read one D16 word
// R10 - Mask ANDed; set needs ones, clear zeros
// R11 - Keep re-reading until bit condition holds
// R12 - Delay misc loops of 3 us between reads
// R13 - Wait-count proceeds when value reaches count
// R14 - 32-bit count read as two D16 reads
// R15 - Repeat count reads with delay until met
// R16 - Control writes misc to selected location
// R17 - 32-bit control target gets two D16 writes
// R18 - Byte counter kept; dump writes its value
// R19 - Shared RAM offset at most 262144
// R20 - Next operation waits for current to finish
// R21 - Code-to-variant mapping chosen by designer
`timescale 1ns/1ps
`default_nettype none
`include "sosm_map.vh"

module sosm_top (
  input  wire        CORE_CLK_I,     // Core clock, 20 MHz
  input  wire        SRST_I,         // Synchronous reset, active high
  input  wire        OP_VALID_I,     // Operation offered
  output wire        OP_READY_O,     // Executor idle, takes operation
  input  wire [15:0] OP_CODE_I,      // Operation code
  input  wire [31:0] OP_COUNT_I,     // Count operand
  input  wire [31:0] OP_ADDR_I,      // Address operand
  input  wire [31:0] OP_MISC_I,      // Misc operand
  output reg         OP_DONE_O,      // Pulse: operation finished
  output reg         OP_ERR_O,       // Pulse: operation refused
  output reg         BUS_REQ_O,      // Bus access request, held to ack
  output reg         BUS_WE_O,       // 1 write, 0 read
  output reg  [1:0]  BUS_SPACE_O,    // Address space
  output reg  [31:0] BUS_ADDR_O,     // Byte address of D16 access
  output reg  [15:0] BUS_WDATA_O,    // Write data
  input  wire        BUS_ACK_I,      // Access complete
  input  wire [15:0] BUS_RDATA_I,    // Read data, valid with ack
  input  wire [15:0] LB_IN_DATA_I,   // Local-bus word in
  input  wire        LB_IN_VALID_I,  // Local-bus word valid
  output wire        LB_IN_READY_O,  // Local-bus word taken
  output reg  [15:0] LB_OUT_DATA_O,  // Outgoing stream word
  output reg         LB_OUT_VALID_O, // Outgoing word valid
  input  wire        LB_OUT_READY_I, // Outgoing word taken
  input  wire        CNT_CLR_I,      // Clear byte counter
  input  wire        XFER_VALID_I,   // Other transfers: bytes valid
  input  wire [15:0] XFER_BYTES_I,   // Other transfers: byte count
  output reg  [31:0] BYTE_CNT_O      // Transferred byte counter
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_RD    = 4'h1;
  localparam [3:0] ST_EVAL  = 4'h2;
  localparam [3:0] ST_DELAY = 4'h3;
  localparam [3:0] ST_WR    = 4'h4;
  localparam [3:0] ST_MSTR  = 4'h5;
  localparam [3:0] ST_MWR   = 4'h6;
  localparam [3:0] ST_FLAG  = 4'h7;
  localparam [3:0] ST_DONE  = 4'h8;

  // ==========================================================
  // Decoding
  function [2:0] op_type;
    input [15:0] code;
    begin
      if (code[15:4] == `SOSM_GRP_WBIT && !code[`SOSM_F_CNTGRP])
        op_type = `SOSM_T_WBIT;
      else if (code[15:4] == `SOSM_GRP_WBIT)
        op_type = `SOSM_T_WCNT;
      else if (code[15:4] == `SOSM_GRP_CTRL && code[`SOSM_F_CNTGRP])
        op_type = `SOSM_T_CTRL;
      else if (code[15:4] == `SOSM_GRP_DUMP && code[3:0] <= `SOSM_DUMP_LAST)
        op_type = `SOSM_T_DUMP;
      else if (code[15:8] == `SOSM_GRP_MON)
        op_type = `SOSM_T_MON;
      else
        op_type = `SOSM_T_BAD;
    end
  endfunction

  function [1:0] op_space;
    input [15:0] code;
    input [2:0]  typ;
    begin
      case (typ)
        `SOSM_T_DUMP: op_space = (code[1:0] == 2'h0) ? `SOSM_SP_A24 :
                                 (code[1:0] == 2'h1) ? `SOSM_SP_A32 :
                                 `SOSM_SP_SRAM;
        `SOSM_T_MON:  op_space = code[`SOSM_F_MONTGT] ? `SOSM_SP_A24 :
                                 `SOSM_SP_SRAM; // R2
        default:      op_space = code[`SOSM_F_SPACE_HI:`SOSM_F_SPACE_LO];
      endcase
    end
  endfunction

  wire [2:0]  in_type  = op_type(OP_CODE_I);           // R21
  wire [1:0]  in_space = op_space(OP_CODE_I, in_type);
  wire        in_badad = (in_space == `SOSM_SP_SRAM) &&
                         (OP_ADDR_I > `SOSM_SRAM_MAX); // R19
  wire [31:0] in_addr  = (in_space == `SOSM_SP_A24) ?
                         (OP_ADDR_I & `SOSM_A24_MASK) : OP_ADDR_I;
  wire [56:0] in_prod  = {{33{1'b0}}, OP_COUNT_I[23:0]} *
                         {{33{1'b0}}, OP_MISC_I[`SOSM_BLKSZ_HI:0]};

  reg [3:0]  state_r;
  reg [2:0]  type_r;
  reg        var_r;      // Clear polarity or 32-bit width
  reg [31:0] base_r;
  reg [31:0] count_r;
  reg [31:0] misc_r;
  reg [31:0] rval_r;
  reg        idx_r;
  reg        copy_r;
  reg [31:0] left_r;     // Monitor bytes still to pass
  reg [31:0] moff_r;     // Monitor write offset past the flag
  reg        dly_start_r;
  wire       dly_done;

  // For wait-bit codes the variant bit is polarity, never width
  wire       two_words = var_r && (type_r != `SOSM_T_WBIT); // R9
  wire [15:0] msk      = count_r[15:0];
  wire [15:0] masked   = rval_r[15:0] & msk;
  wire       bit_met   = var_r ? (masked == 16'h0000) :
                                 (masked == msk);      // R10
  wire [31:0] cnt_need = var_r ? count_r : {16'h0000, count_r[15:0]};
  wire       cnt_met   = (rval_r >= cnt_need);         // R13
  wire       lb_take   = (state_r == ST_MSTR) && LB_IN_VALID_I &&
                         !LB_OUT_VALID_O && (left_r != 32'h0);
  wire       out_take  = LB_OUT_VALID_O && LB_OUT_READY_I;
  wire       mon_pass  = lb_take;

  // R20
  assign OP_READY_O    = (state_r == ST_IDLE);
  assign LB_IN_READY_O = lb_take;

  function [15:0] wr_word;
    input [2:0]  typ;
    input        two;
    input        idx;
    input [31:0] misc;
    input [31:0] cnt;
    begin
      case (typ)
        `SOSM_T_CTRL: wr_word = (two && !idx) ? misc[31:16] :
                                misc[15:0];           // R16 R17
        `SOSM_T_DUMP: wr_word = idx ? cnt[15:0] : cnt[31:16];
        default:      wr_word = idx ? `SOSM_FLAG_SET_LO :
                                `SOSM_FLAG_SET_HI;
      endcase
    end
  endfunction

  sosm_delay u_delay (
    .clk_i   (CORE_CLK_I),
    .srst_i  (SRST_I),
    .start_i (dly_start_r),
    .loops_i (misc_r),
    .done_o  (dly_done)
  );

  // ==========================================================
  // Byte counter
  always @(posedge CORE_CLK_I) begin
    if (SRST_I || CNT_CLR_I) begin
      BYTE_CNT_O <= 32'h0;
    end else begin
      // Both sources may land in one cycle; neither is dropped
      BYTE_CNT_O <= BYTE_CNT_O +
                    (XFER_VALID_I ? {16'h0000, XFER_BYTES_I} : 32'h0) +
                    (mon_pass ? `SOSM_WORD_BYTES : 32'h0); // R18
    end
  end

  // ==========================================================
  // Outgoing stream register
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      LB_OUT_VALID_O <= 1'b0;
      LB_OUT_DATA_O  <= 16'h0000;
    end else if (lb_take) begin
      LB_OUT_VALID_O <= 1'b1;                          // R7
      LB_OUT_DATA_O  <= LB_IN_DATA_I;
    end else if (out_take) begin
      LB_OUT_VALID_O <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_r     <= ST_IDLE;
      type_r      <= `SOSM_T_BAD;
      var_r       <= 1'b0;
      base_r      <= 32'h0;
      count_r     <= 32'h0;
      misc_r      <= 32'h0;
      rval_r      <= 32'h0;
      idx_r       <= 1'b0;
      copy_r      <= 1'b0;
      left_r      <= 32'h0;
      moff_r      <= 32'h0;
      dly_start_r <= 1'b0;
      OP_DONE_O   <= 1'b0;
      OP_ERR_O    <= 1'b0;
      BUS_REQ_O   <= 1'b0;
      BUS_WE_O    <= 1'b0;
      BUS_SPACE_O <= `SOSM_SP_A16;
      BUS_ADDR_O  <= 32'h0;
      BUS_WDATA_O <= 16'h0000;
    end else begin
      OP_DONE_O   <= 1'b0;
      OP_ERR_O    <= 1'b0;
      dly_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (OP_VALID_I) begin
            type_r      <= in_type;
            var_r       <= OP_CODE_I[`SOSM_F_VARIANT] ||
                           (in_type == `SOSM_T_DUMP) ||
                           (in_type == `SOSM_T_MON);
            base_r      <= in_addr;
            count_r     <= OP_COUNT_I;
            misc_r      <= OP_MISC_I;
            BUS_SPACE_O <= in_space;
            left_r      <= in_prod[31:0];              // R3
            moff_r      <= `SOSM_FLAG_BYTES;           // R4
            idx_r       <= 1'b0;
            if (in_type == `SOSM_T_BAD || in_badad) begin
              OP_ERR_O <= 1'b1;
              OP_DONE_O <= 1'b1;
            end else if (in_type == `SOSM_T_CTRL ||
                         in_type == `SOSM_T_DUMP) begin
              state_r <= ST_WR;
            end else begin
              state_r <= ST_RD;                        // R9 R14
            end
          end
        end
        ST_RD: begin
          if (!BUS_REQ_O) begin
            BUS_REQ_O  <= 1'b1;
            BUS_WE_O   <= 1'b0;
            BUS_ADDR_O <= base_r + {30'h0, idx_r, 1'b0};
          end else if (BUS_ACK_I) begin
            BUS_REQ_O <= 1'b0;
            if (two_words && !idx_r) begin
              rval_r[31:16] <= BUS_RDATA_I;
              idx_r         <= 1'b1;
            end else begin
              rval_r <= two_words ? {rval_r[31:16], BUS_RDATA_I} :
                                    {16'h0000, BUS_RDATA_I};
              state_r <= ST_EVAL;
            end
          end
        end
        ST_EVAL: begin
          idx_r <= 1'b0;
          if (type_r == `SOSM_T_MON) begin
            copy_r  <= (rval_r == 32'h0);              // R5 R7
            state_r <= ST_MSTR;
          end else if ((type_r == `SOSM_T_WBIT && bit_met) ||
                       (type_r == `SOSM_T_WCNT && cnt_met)) begin
            state_r <= ST_DONE;
          end else begin
            dly_start_r <= 1'b1;                       // R12
            state_r     <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dly_done) begin
            state_r <= ST_RD;                          // R11 R15
          end
        end
        ST_WR: begin
          if (!BUS_REQ_O) begin
            BUS_REQ_O   <= 1'b1;
            BUS_WE_O    <= 1'b1;
            BUS_ADDR_O  <= base_r + {30'h0, idx_r, 1'b0};
            BUS_WDATA_O <= wr_word(type_r, two_words, idx_r,
                                   misc_r, BYTE_CNT_O);
          end else if (BUS_ACK_I) begin
            BUS_REQ_O <= 1'b0;
            if (two_words && !idx_r) begin
              idx_r <= 1'b1;                           // R17
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_MSTR: begin
          if (left_r == 32'h0) begin
            // Flag is written only after the whole block has landed
            idx_r   <= 1'b0;
            state_r <= copy_r ? ST_FLAG : ST_DONE;
          end else if (lb_take) begin
            left_r <= left_r - `SOSM_WORD_BYTES;
            if (copy_r) begin
              BUS_REQ_O   <= 1'b1;
              BUS_WE_O    <= 1'b1;
              BUS_ADDR_O  <= base_r + moff_r;          // R1
              BUS_WDATA_O <= LB_IN_DATA_I;             // R2
              state_r     <= ST_MWR;
            end
          end
        end
        ST_MWR: begin
          if (BUS_ACK_I) begin
            BUS_REQ_O <= 1'b0;
            moff_r    <= moff_r + `SOSM_WORD_BYTES;    // R1
            state_r   <= ST_MSTR;
          end
        end
        ST_FLAG: begin
          state_r <= ST_WR;                            // R5
        end
        ST_DONE: begin
          OP_DONE_O <= 1'b1;                           // R20
          state_r   <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== hdl/sosm_map.vh ====
`ifndef SOSM_MAP_VH
`define SOSM_MAP_VH

// Clock and delay-loop timing
`define SOSM_CLK_NS        50
`define SOSM_LOOP_NS       3000
`define SOSM_LOOP_CYC      ((`SOSM_LOOP_NS + `SOSM_CLK_NS - 1) / `SOSM_CLK_NS)

// Operation code groups (upper 12 bits of the 16-bit code, upper 8 bits for monitor)
`define SOSM_GRP_WBIT      12'h600
`define SOSM_GRP_CTRL      12'h601
`define SOSM_GRP_DUMP      12'h602
`define SOSM_GRP_MON       8'h50
`define SOSM_DUMP_LAST     4'h2

// Code field positions
`define SOSM_F_SPACE_HI    1
`define SOSM_F_SPACE_LO    0
`define SOSM_F_VARIANT     2
`define SOSM_F_CNTGRP      3
`define SOSM_F_MONTGT      0

// Address spaces on the bus port
`define SOSM_SP_A16        2'h0
`define SOSM_SP_A24        2'h1
`define SOSM_SP_A32        2'h2
`define SOSM_SP_SRAM       2'h3

// Offset limits
`define SOSM_SRAM_MAX      32'h00040000
`define SOSM_A24_MASK      32'h00ffffff

// Monitor region layout
`define SOSM_FLAG_BYTES    32'h00000004
`define SOSM_FLAG_SET_HI   16'h0000
`define SOSM_FLAG_SET_LO   16'h0001
`define SOSM_BLKSZ_HI      23
`define SOSM_WORD_BYTES    32'h00000002

// Internal operation types
`define SOSM_T_BAD         3'h0
`define SOSM_T_WBIT        3'h1
`define SOSM_T_WCNT        3'h2
`define SOSM_T_CTRL        3'h3
`define SOSM_T_DUMP        3'h4
`define SOSM_T_MON         3'h5

`endif

// ==== hdl/sosm_delay.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sosm_map.vh"

module sosm_delay (
  input  wire        clk_i,     // Core clock
  input  wire        srst_i,    // Synchronous reset, active high
  input  wire        start_i,   // Pulse: begin a delay
  input  wire [31:0] loops_i,   // Number of delay loops
  output reg         done_o     // Pulse: delay elapsed
);

  localparam [31:0] LOOP_CYC_W = `SOSM_LOOP_CYC;
  localparam [7:0]  LOOP_CYC   = LOOP_CYC_W[7:0];

  reg        busy_r;
  reg [31:0] loops_r;
  reg [7:0]  cyc_r;

  // ==========================================================
  // Loop counter
  always @(posedge clk_i) begin
    if (srst_i) begin
      busy_r  <= 1'b0;
      loops_r <= 32'h0;
      cyc_r   <= 8'h0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        // Zero loops still costs one cycle, keeping the caller simple
        busy_r  <= (loops_i != 32'h0);
        done_o  <= (loops_i == 32'h0);
        loops_r <= loops_i;
        cyc_r   <= LOOP_CYC - 8'h01;
      end else if (busy_r) begin
        if (cyc_r != 8'h0) begin
          cyc_r <= cyc_r - 8'h01;
        end else if (loops_r == 32'h1) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
        end else begin
          loops_r <= loops_r - 32'h1;
          cyc_r   <= LOOP_CYC - 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== verif/sosm_chk_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Executor protocol checker
module sosm_chk (
  input wire logic        CORE_CLK_I,  // Clock
  input wire logic        SRST_I,      // Reset
  input wire logic        OP_VALID_I,  // Op offered
  input wire logic        OP_READY_O,  // Op taken
  input wire logic [15:0] OP_CODE_I,   // Code
  input wire logic [31:0] OP_ADDR_I,   // Address
  input wire logic [31:0] OP_MISC_I,   // Misc
  input wire logic        OP_DONE_O,   // Done
  input wire logic        OP_ERR_O,    // Refused
  input wire logic        BUS_REQ_O,   // Request
  input wire logic        BUS_WE_O,    // Write
  input wire logic [1:0]  BUS_SPACE_O, // Space
  input wire logic [31:0] BUS_ADDR_O,  // Address
  input wire logic [15:0] BUS_WDATA_O, // Write data
  input wire logic        BUS_ACK_I    // Ack
);
  localparam int LOOP_CYC = 60;
  logic [15:0] code_r;
  logic [31:0] addr_r;
  logic [31:0] misc_r;
  logic [15:0] gap_r;
  logic        acked_r;
  wire         take = OP_VALID_I && OP_READY_O;
  wire         wbit = code_r[15:3] == 13'h0c00;
  wire         ctrl = code_r[15:3] == 13'h0c03;
  // Operands are kept so bus traffic can be tied back to its op
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      code_r <= 16'h0000;
      addr_r <= 32'h0;
      misc_r <= 32'h0;
      acked_r <= 1'b0;
      gap_r <= 16'h0000;
    end else begin
      gap_r <= BUS_ACK_I ? 16'h0000 : gap_r + 16'h0001;
      if (take) begin
        code_r <= OP_CODE_I;
        addr_r <= OP_ADDR_I;
        misc_r <= OP_MISC_I;
        acked_r <= 1'b0;
      end else if (BUS_ACK_I)
        acked_r <= 1'b1;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  AST_REQ_HOLD: assert property (BUS_REQ_O && !BUS_ACK_I |=>
    BUS_REQ_O && $stable({BUS_WE_O, BUS_SPACE_O, BUS_ADDR_O, BUS_WDATA_O}))
    else $error("bus request changed before ack");
  AST_REQ_GAP: assert property (BUS_REQ_O && BUS_ACK_I |=> !BUS_REQ_O)
    else $error("no idle cycle after bus ack");
  AST_BUSY: assert property (BUS_REQ_O |-> !OP_READY_O)
    else $error("new op offered during bus access");
  AST_REFUSE: assert property (take && OP_CODE_I[15:3] == 13'h0c02
    |-> ##[1:2] (OP_DONE_O && OP_ERR_O)) else $error("unknown code not refused");
  AST_SRAM_LIMIT: assert property (take && OP_CODE_I == 16'h6022 &&
    OP_ADDR_I > 32'h0004_0000 |-> ##[1:2] OP_ERR_O)
    else $error("offset beyond shared RAM accepted");
  AST_WAIT_RD: assert property (BUS_REQ_O && wbit |->
    !BUS_WE_O && BUS_SPACE_O == code_r[1:0]) else $error("bad poll access");
  AST_CTRL_WR: assert property (BUS_REQ_O && ctrl |->
    BUS_WE_O && BUS_SPACE_O == code_r[1:0]) else $error("bad control access");
  AST_CTRL_HALF: assert property ($rose(BUS_REQ_O) && ctrl && code_r[2] |->
    BUS_WDATA_O == (BUS_ADDR_O[23:0] == addr_r[23:0] ?
    misc_r[31:16] : misc_r[15:0])) else $error("control half misplaced");
  AST_DELAY: assert property ($rose(BUS_REQ_O) && wbit && acked_r |->
    gap_r + 16'h0002 >= LOOP_CYC * misc_r[7:0]) else $error("poll too early");
  AST_DONE_LAT: assert property (OP_DONE_O && !OP_ERR_O &&
    code_r[15:8] == 8'h60 |-> $past(BUS_ACK_I) || $past(BUS_ACK_I, 2) ||
    $past(BUS_ACK_I, 3)) else $error("done not tied to last access");
  AST_MON_SPACE: assert property (BUS_REQ_O && code_r[15:8] == 8'h50 |->
    BUS_SPACE_O == (code_r[0] ? 2'h1 : 2'h3)) else $error("bad monitor space");
  cover property (take && OP_CODE_I[15:3] == 13'h0c03);
  cover property ($rose(BUS_REQ_O) && wbit && acked_r);
  cover property (OP_ERR_O);
endmodule
bind sosm_top sosm_chk chk_u (.CORE_CLK_I, .SRST_I, .OP_VALID_I, .OP_READY_O,
  .OP_CODE_I, .OP_ADDR_I, .OP_MISC_I, .OP_DONE_O, .OP_ERR_O, .BUS_REQ_O,
  .BUS_WE_O, .BUS_SPACE_O, .BUS_ADDR_O, .BUS_WDATA_O, .BUS_ACK_I);
`default_nettype wire

// ==== verif/sosm_bus_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus memory and devices
module sosm_bus_mem (
  input  wire logic        clk_i,   // Clock
  input  wire logic        req_i,   // Request
  input  wire logic        we_i,    // Write
  input  wire logic [1:0]  space_i, // Space
  input  wire logic [31:0] addr_i,  // Address
  input  wire logic [15:0] wdata_i, // Write data
  input  wire logic [3:0]  lat_i,   // Ack delay
  output logic             ack_o,   // Ack
  output logic [15:0]      rdata_o  // Read data
);
  logic [15:0] mem [logic [33:0]];
  logic [3:0]  wait_r = 4'h0;
  int          wr_count = 0;
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
  end
  function automatic logic [15:0] rd(input logic [1:0] s, logic [31:0] a);
    return mem.exists({s, a}) ? mem[{s, a}] : 16'h0000;
  endfunction
  // Data lines toggle off ack so a stale word never looks valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o && wait_r < lat_i)
      wait_r <= wait_r + 4'h1;
    else if (req_i && !ack_o) begin
      wait_r <= 4'h0;
      ack_o <= 1'b1;
      if (we_i) begin
        mem[{space_i, addr_i}] = wdata_i;
        wr_count++;
      end else
        rdata_o <= rd(space_i, addr_i);
    end
  end
endmodule
`default_nettype wire

// ==== verif/sosm_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench
module sosm_top_tb_top;
  logic        clk = 1'b0, srst = 1'b1, op_v = 1'b0, cclr = 1'b1;
  logic        xv = 1'b0, lb_v = 1'b0, lor = 1'b1;
  logic [15:0] code = 16'h0000, xb = 16'h1234, lb_d = 16'h0000;
  logic [31:0] cnt = 32'h0, addr = 32'h0, misc = 32'h0;
  logic [31:0] exp_bytes = 32'h1234;
  logic [3:0]  lat = 4'h0;
  wire         rdy, done, err, req, we, ack, lbr, lov;
  wire  [1:0]  sp;
  wire  [31:0] ba, bc;
  wire  [15:0] wd, rd, lod;
  int          bad_count = 0, checked = 0, wr0;
  bit          got;
  logic [15:0] outq[$];
  sosm_top dut_u (
    .CORE_CLK_I(clk), .SRST_I(srst), .OP_VALID_I(op_v), .OP_READY_O(rdy),
    .OP_CODE_I(code), .OP_COUNT_I(cnt), .OP_ADDR_I(addr), .OP_MISC_I(misc),
    .OP_DONE_O(done), .OP_ERR_O(err), .BUS_REQ_O(req), .BUS_WE_O(we),
    .BUS_SPACE_O(sp), .BUS_ADDR_O(ba), .BUS_WDATA_O(wd), .BUS_ACK_I(ack),
    .BUS_RDATA_I(rd), .LB_IN_DATA_I(lb_d), .LB_IN_VALID_I(lb_v),
    .LB_IN_READY_O(lbr), .LB_OUT_DATA_O(lod), .LB_OUT_VALID_O(lov),
    .LB_OUT_READY_I(lor), .CNT_CLR_I(cclr), .XFER_VALID_I(xv),
    .XFER_BYTES_I(xb), .BYTE_CNT_O(bc));
  sosm_bus_mem mem_u (.clk_i(clk), .req_i(req), .we_i(we), .space_i(sp),
    .addr_i(ba), .wdata_i(wd), .lat_i(lat), .ack_o(ack), .rdata_o(rd));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (lov === 1'b1 && lor) outq.push_back(lod);
  task automatic chk(input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send_op(input logic [15:0] c, input logic [31:0] n, a, m);
    int i = 0;
    op_v <= 1'b1;
    code <= c;
    cnt <= n;
    addr <= a;
    misc <= m;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 50);
    op_v <= 1'b0;
    chk(1, rdy);
    if (rdy !== 1'b1) print_verdict;
  endtask
  task automatic wait_done(input int n, input bit must, input logic e);
    got = 0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge clk);
      got = (done === 1'b1);
    end
    if (got) chk(e, err);
    chk(must, got);
    if (must && !got) print_verdict;
  endtask
  task automatic put(input logic [1:0] s, input logic [31:0] a, w, input bit t);
    mem_u.mem[{s, a}] = t ? w[31:16] : w[15:0];
    if (t) mem_u.mem[{s, a + 32'h2}] = w[15:0];
  endtask
  task automatic feed(input logic [15:0] b);
    int i;
    for (int k = 0; k < 2; k++) begin
      lb_d <= b + 16'(k);
      lb_v <= 1'b1;
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (lbr !== 1'b1 && i < 300);
      if (lbr !== 1'b1) begin
        chk(1, 0);
        print_verdict;
      end
      // Stall the outgoing side once so the held word is exercised
      if (k == 0) begin
        lor <= 1'b0;
        repeat (3) @(posedge clk);
        lor <= 1'b1;
      end
    end
    lb_v <= 1'b0;
  endtask
  task automatic t_ctrl;
    logic [31:0] at[4] = '{32'h10, 32'h0100_0020, 32'h2000_0030, 32'h0004_0000};
    for (int s = 0; s < 4; s++) begin
      send_op(16'h6018 + 16'(s), 0, at[s], 32'h5a5a_0000 + s);
      wait_done(60, 1, 0);
      chk(s, mem_u.rd(2'(s), s == 1 ? at[s] & 32'h00ff_ffff : at[s]));
    end
    lat <= 4'h3;
    wr0 = mem_u.wr_count;
    send_op(16'h601e, 0, 32'h1000_0000, 32'hcafe_beef);
    wait_done(80, 1, 0);
    chk(16'hcafe, mem_u.rd(2'h2, 32'h1000_0000));
    chk(16'hbeef, mem_u.rd(2'h2, 32'h1000_0002));
    chk(2, mem_u.wr_count - wr0);
    lat <= 4'h0;
    $display("control test done");
  endtask
  task automatic t_ref;
    wr0 = mem_u.wr_count;
    send_op(16'h6010, 0, 0, 0);
    wait_done(5, 1, 1);
    send_op(16'h6022, 0, 32'h0004_0001, 0);
    wait_done(5, 1, 1);
    chk(wr0, mem_u.wr_count);
    $display("refusal test done");
  endtask
  // The bad value must hold the op; the good one must release it
  task automatic t_wait(input logic [15:0] c, input logic [31:0] a, n, wb, wg);
    put(c[1:0], a, wb, c[3] && c[2]);
    send_op(c, n, a, 32'h1);
    wait_done(300, 0, 0);
    put(c[1:0], a, wg, c[3] && c[2]);
    wait_done(300, 1, 0);
    $display("wait test done");
  endtask
  task automatic t_mon(input logic [15:0] c, fl);
    logic [1:0]  s = c[0] ? 2'h1 : 2'h3;
    logic [15:0] b = c ^ fl;
    put(s, 32'h1000, {16'h0000, fl}, 1);
    wr0 = mem_u.wr_count;
    outq.delete();
    fork
      send_op(c, 1, 32'h1000, 4);
      feed(b);
    join
    wait_done(100, 1, 0);
    exp_bytes += 4;
    chk(2, outq.size());
    chk(b, outq[0]);
    chk(b + 16'h1, outq[1]);
    chk(fl == 0 ? 4 : 0, mem_u.wr_count - wr0);
    if (fl == 0) begin
      chk(b, mem_u.rd(s, 32'h1004));
      chk(b + 16'h1, mem_u.rd(s, 32'h1006));
      chk(32'h1, {mem_u.rd(s, 32'h1000), mem_u.rd(s, 32'h1002)});
    end
    $display("monitor test done");
  endtask
  task automatic t_dump;
    chk(exp_bytes, bc);
    for (int d = 0; d < 3; d++) begin
      send_op(16'h6020 + 16'(d), 0, 32'h300, 0);
      wait_done(80, 1, 0);
      chk(exp_bytes, {mem_u.rd(2'(d + 1), 32'h300),
        mem_u.rd(2'(d + 1), 32'h302)});
    end
    $display("dump test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    cclr <= 1'b0;
    xv <= 1'b1;
    @(posedge clk);
    xv <= 1'b0;
    chk(1, rdy);
    t_ctrl;
    t_ref;
    t_wait(16'h6001, 32'h80, 32'h118, 32'h00f0, 32'h01f8);
    t_wait(16'h6005, 32'h80, 32'h118, 32'h0100, 32'hfee7);
    t_wait(16'h6009, 32'h90, 32'h5, 32'h4, 32'h5);
    t_wait(16'h600e, 32'h200, 32'h10000, 32'hffff, 32'h10000);
    t_mon(16'h5000, 16'h0001);
    t_mon(16'h5000, 16'h0000);
    t_mon(16'h5001, 16'h0000);
    t_dump;
    print_verdict;
  end
endmodule
`default_nettype wire
